// ==== hw/ioc_top.sv ====
/*
  Internal oscillator control: system clock source select, fast oscillator
  range, post-divider and trim, constant medium-frequency ticks, ready status,
  manual enables and the clock/ADC interrupt enable and flag registers.
  Assumes a synchronous Wishbone master and oscillator ready inputs timed to clk_i.
*/
// Functional notes
// - reset config 110 or 000 starts fast oscillator
// - writing new-source select switches system clock
// - internal source frees external clock pin
// - config bit selects clock output or GPIO
// - fast up to 32 MHz, slow 31 kHz
// - three-bit field selects fast frequency
// - medium outputs 500 kHz and 32 kHz
// - four-bit divider from 1:1 to 1:512
// - trim is 6-bit signed, resets zero
// - 1Fh max up, 20h max down
// - trim drifts gradually, no completion flag
// - trim never affects slow oscillator
// - slow oscillator clocks timers, watchdog, monitor
// - slow always enabled, whatever the reset config or select
// - read-only per-oscillator ready status
// - manual enable runs oscillator independently
// - switch flag bit 6 sticky until cleared
// - ADC flag bit 0 sticky until cleared
// - flags set regardless of enables
`timescale 1ns/1ps
`include "ioc_defines.svh"

module ioc_top #(
  parameter int TRIM_STEP_CYC = `IOC_TRIM_STEP_CYC,
  parameter int READY_CYC     = `IOC_READY_CYC,
  parameter int MF_500K_DIV   = 400,
  parameter int MF_32K_DIV    = 6250
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire ioc_pkg::ioc_wb_req_t wb_req_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [2:0]           reset_clock_source_cfg_i,
  input  wire logic                 clock_output_pin_enable_i,
  input  wire logic                 osc_fail_i,
  input  wire logic                 adc_done_i,
  input  wire logic                 adc_threshold_i,
  input  wire logic                 hf_osc_ready_i,
  input  wire logic                 lf_osc_ready_i,
  output logic                      fast_osc_en_o,
  output logic                      slow_osc_en_o,
  output logic [2:0]                fast_freq_o,
  output logic [5:0]                trim_o,
  output logic [3:0]                clock_divider_o,
  output logic [2:0]                sys_clk_src_o,
  output logic                      ext_clock_input_gpio_o,
  output logic                      clock_output_drive_o,
  output ioc_pkg::ioc_mf_clk_t      mf_tick_o,
  output logic                      lf_peripheral_en_o,
  output logic                      int_req_o
);
  import ioc_pkg::*;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic [31:0] rd_nxt;
  logic        ack_r;
  assign acc = wb_req_i.cyc && wb_req_i.stb && !ack_r;
  assign wr  = acc && wb_req_i.we && wb_req_i.sel[0];

  logic [2:0] new_source_select_r;
  logic [3:0] clock_divider_field_r;
  logic [2:0] fast_freq_field_r;
  logic [5:0] osc_trim_reg_r;
  logic [1:0] osc_manual_enable_r;
  logic [7:0] int_en_r;
  logic [7:0] int_flag_r;
  logic [2:0] cur_src_r;
  logic [5:0] trim_eff_r;
  logic       cfg_loaded_r;
  ioc_sw_state_t sw_state_r;

  // ------------------------------------------------------------
  // clock source control
  // ------------------------------------------------------------
  // strap is sampled in the first clock after reset release, never under reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_loaded_r          <= 1'b0;
      new_source_select_r   <= `IOC_SRC_HF_32M;
      fast_freq_field_r     <= `IOC_FRQ_32M;
      clock_divider_field_r <= 4'h0;
    end else if (!cfg_loaded_r) begin
      cfg_loaded_r        <= 1'b1;
      new_source_select_r <= reset_clock_source_cfg_i;
      fast_freq_field_r   <= (reset_clock_source_cfg_i == `IOC_SRC_HF_1M) ? `IOC_FRQ_1M : `IOC_FRQ_32M;
    end else if (wr && wb_req_i.adr == `IOC_OFF_SRC_CTRL) begin
      new_source_select_r <= wb_req_i.dat[6:4];
      // ratios beyond 1:512 saturate
      clock_divider_field_r <= (wb_req_i.dat[3:0] > `IOC_DIV_CODE_MAX) ? `IOC_DIV_CODE_MAX : wb_req_i.dat[3:0];
    end else if (wr && wb_req_i.adr == `IOC_OFF_FRQ_SEL) begin
      fast_freq_field_r <= wb_req_i.dat[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_trim_reg_r      <= `IOC_TRIM_RST;
      osc_manual_enable_r <= 2'b00;
      int_en_r            <= 8'h00;
    end else if (wr) begin
      if (wb_req_i.adr == `IOC_OFF_TRIM)
        osc_trim_reg_r <= wb_req_i.dat[5:0];
      if (wb_req_i.adr == `IOC_OFF_MAN_EN)
        osc_manual_enable_r <= wb_req_i.dat[1:0];
      if (wb_req_i.adr == `IOC_OFF_INT_EN)
        int_en_r <= wb_req_i.dat[7:0] & `IOC_INT_MASK;
    end
  end

  // ------------------------------------------------------------
  // switch sequencer
  // ------------------------------------------------------------
  logic is_lf_req;
  logic target_ready;
  logic sw_done;
  assign is_lf_req    = (new_source_select_r == `IOC_SRC_LF);
  assign target_ready = is_lf_req ? lf_osc_ready_i : hf_osc_ready_i;
  assign sw_done      = (sw_state_r == IOC_SW_WAIT) && target_ready;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_state_r <= IOC_SW_IDLE;
      cur_src_r  <= `IOC_SRC_HF_32M;
    end else begin
      unique case (sw_state_r)
        IOC_SW_IDLE: begin
          if (cfg_loaded_r && new_source_select_r != cur_src_r)
            sw_state_r <= IOC_SW_WAIT;
        end
        IOC_SW_WAIT: begin
          if (target_ready) begin
            sw_state_r <= IOC_SW_DONE;
            cur_src_r  <= new_source_select_r;
          end
        end
        IOC_SW_DONE: sw_state_r <= IOC_SW_IDLE;
        default:     sw_state_r <= IOC_SW_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // trim drift: one step per interval, no done indication
  // ------------------------------------------------------------
  logic [15:0] trim_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_eff_r <= `IOC_TRIM_RST;
      trim_cnt_r <= 16'h0000;
    end else if (trim_eff_r == osc_trim_reg_r) begin
      trim_cnt_r <= 16'h0000;
    end else if (trim_cnt_r == 16'(TRIM_STEP_CYC - 1)) begin
      trim_cnt_r <= 16'h0000;
      // signed compare so 1Fh is the top and 20h the bottom
      if ($signed(osc_trim_reg_r) > $signed(trim_eff_r))
        trim_eff_r <= trim_eff_r + 6'h01;
      else
        trim_eff_r <= trim_eff_r - 6'h01;
    end else begin
      trim_cnt_r <= trim_cnt_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // medium-frequency constant ticks
  // ------------------------------------------------------------
  logic [15:0] mf_cnt_r [2];
  logic [1:0]  mf_tick_r;
  localparam int MF_DIV [2] = '{MF_500K_DIV, MF_32K_DIV};
  for (genvar g = 0; g < 2; g++) begin : g_mf
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mf_cnt_r[g]  <= 16'h0000;
        mf_tick_r[g] <= 1'b0;
      end else if (mf_cnt_r[g] == 16'(MF_DIV[g] - 1)) begin
        mf_cnt_r[g]  <= 16'h0000;
        mf_tick_r[g] <= 1'b1;
      end else begin
        mf_cnt_r[g]  <= mf_cnt_r[g] + 16'h0001;
        mf_tick_r[g] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt flags: hardware set beats software clear
  // ------------------------------------------------------------
  logic [7:0] flag_set;
  logic       flag_wr;
  always_comb begin
    flag_set = 8'h00;
    flag_set[`IOC_BIT_OSF] = osc_fail_i;
    flag_set[`IOC_BIT_CSW] = sw_done;
    flag_set[`IOC_BIT_ADT] = adc_threshold_i;
    flag_set[`IOC_BIT_AD]  = adc_done_i;
  end
  assign flag_wr = wr && wb_req_i.adr == `IOC_OFF_INT_FLAG;

  always_ff @(posedge clk_i) begin
    if (rst_i)
      int_flag_r <= 8'h00;
    else if (flag_wr)
      int_flag_r <= ((wb_req_i.dat[7:0] & `IOC_INT_MASK) | flag_set);
    else
      int_flag_r <= int_flag_r | flag_set;
  end

  // ------------------------------------------------------------
  // read mux and ack
  // ------------------------------------------------------------
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (wb_req_i.adr)
      `IOC_OFF_SRC_CTRL: rd_nxt[6:0] = {new_source_select_r, clock_divider_field_r};
      `IOC_OFF_FRQ_SEL:  rd_nxt[2:0] = fast_freq_field_r;
      `IOC_OFF_TRIM:     rd_nxt[5:0] = osc_trim_reg_r;
      `IOC_OFF_STATUS:   rd_nxt[1:0] = {hf_osc_ready_i, lf_osc_ready_i};
      `IOC_OFF_MAN_EN:   rd_nxt[1:0] = osc_manual_enable_r;
      `IOC_OFF_INT_EN:   rd_nxt[7:0] = int_en_r;
      `IOC_OFF_INT_FLAG: rd_nxt[7:0] = int_flag_r;
      `IOC_OFF_CURRENT:  rd_nxt[2:0] = cur_src_r;
      default:           rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_r    <= acc;
      wb_dat_o <= acc ? rd_nxt : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack_r;

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  logic cur_internal;
  assign cur_internal = (cur_src_r == `IOC_SRC_HF_32M) || (cur_src_r == `IOC_SRC_HF_1M)
                        || (cur_src_r == `IOC_SRC_LF);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_osc_en_o          <= 1'b0;
      slow_osc_en_o          <= 1'b0;
      fast_freq_o            <= `IOC_FRQ_32M;
      trim_o                 <= `IOC_TRIM_RST;
      clock_divider_o        <= 4'h0;
      sys_clk_src_o          <= `IOC_SRC_HF_32M;
      ext_clock_input_gpio_o <= 1'b0;
      clock_output_drive_o   <= 1'b0;
      mf_tick_o              <= '0;
      lf_peripheral_en_o     <= 1'b0;
      int_req_o              <= 1'b0;
    end else begin
      fast_osc_en_o   <= (cfg_loaded_r && !is_lf_req) || !(cur_src_r == `IOC_SRC_LF)
                         || osc_manual_enable_r[1];
      slow_osc_en_o   <= (cfg_loaded_r && is_lf_req) || (cur_src_r == `IOC_SRC_LF)
                         || osc_manual_enable_r[0] || 1'b1;
      fast_freq_o     <= fast_freq_field_r;
      trim_o          <= trim_eff_r;
      clock_divider_o <= clock_divider_field_r;
      sys_clk_src_o   <= cur_src_r;
      ext_clock_input_gpio_o <= cur_internal;
      clock_output_drive_o   <= clock_output_pin_enable_i;
      mf_tick_o       <= '{clk_500k: mf_tick_r[0], clk_32k: mf_tick_r[1]};
      lf_peripheral_en_o <= 1'b1;
      int_req_o       <= |(int_flag_r & int_en_r);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_switch_req;
    sw_state_r == IOC_SW_WAIT && target_ready;
  endsequence
  sequence s_flag_seen;
    ##1 int_flag_r[`IOC_BIT_CSW];
  endsequence

  a_switch_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_switch_req |-> s_flag_seen) else $error("switch flag not set on completion");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    int_flag_r[`IOC_BIT_AD] && !flag_wr |=> int_flag_r[`IOC_BIT_AD]) else $error("adc flag lost");
  a_flag_ungated: assert property (@(posedge clk_i) disable iff (rst_i)
    adc_threshold_i |=> int_flag_r[`IOC_BIT_ADT]) else $error("threshold flag not set");
  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (int_flag_r[5:2] == 4'h0) && (int_en_r[5:2] == 4'h0)) else $error("unimplemented bits set");
  a_int_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    (int_en_r == 8'h00) |=> !int_req_o) else $error("interrupt without enable");
  a_trim_step: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(trim_eff_r) |-> (trim_eff_r - $past(trim_eff_r) == 6'h01)
      || ($past(trim_eff_r) - trim_eff_r == 6'h01)) else $error("trim jumped");
  a_div_range: assert property (@(posedge clk_i) disable iff (rst_i)
    clock_divider_field_r <= `IOC_DIV_CODE_MAX) else $error("divider out of range");
  a_gpio_free: assert property (@(posedge clk_i) disable iff (rst_i)
    cur_src_r == `IOC_SRC_LF |=> ext_clock_input_gpio_o) else $error("clock pin not released");
  a_src_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_state_r == IOC_SW_DONE |-> cur_src_r == new_source_select_r || $changed(new_source_select_r))
    else $error("switch target mismatch");
endmodule

// ==== inc/ioc_defines.svh ====
/*
  Register offsets, field positions, reset values and timing counts for the
  internal oscillator control block.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
`ifndef IOC_DEFINES_SVH
`define IOC_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define IOC_OFF_SRC_CTRL   8'h00
`define IOC_OFF_FRQ_SEL    8'h04
`define IOC_OFF_TRIM       8'h08
`define IOC_OFF_STATUS     8'h0C
`define IOC_OFF_MAN_EN     8'h10
`define IOC_OFF_INT_EN     8'h14
`define IOC_OFF_INT_FLAG   8'h18
`define IOC_OFF_CURRENT    8'h1C

// ------------------------------------------------------------
// source codes and reset values
// ------------------------------------------------------------
`define IOC_SRC_HF_32M     3'h0
`define IOC_SRC_LF         3'h5
`define IOC_SRC_HF_1M      3'h6
`define IOC_FRQ_32M        3'h6
`define IOC_FRQ_1M         3'h0
`define IOC_TRIM_RST       6'h00
`define IOC_TRIM_MAX_UP    6'h1F
`define IOC_TRIM_MAX_DN    6'h20
`define IOC_DIV_CODE_MAX   4'h9

// ------------------------------------------------------------
// interrupt bit positions
// ------------------------------------------------------------
`define IOC_BIT_OSF        7
`define IOC_BIT_CSW        6
`define IOC_BIT_ADT        1
`define IOC_BIT_AD         0
`define IOC_INT_MASK       8'hC3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define IOC_CLK_MHZ        200
`define IOC_TRIM_STEP_NS   40
`define IOC_TRIM_STEP_CYC  ((`IOC_TRIM_STEP_NS * `IOC_CLK_MHZ) / 1000)
`define IOC_READY_CYC      16

`endif

// ==== inc/ioc_pkg.sv ====
/*
  Types shared by the internal oscillator control block.
  Assumes ioc_defines.svh supplies the numeric constants.
*/
package ioc_pkg;
  typedef enum logic [1:0] {
    IOC_SW_IDLE = 2'b00,
    IOC_SW_WAIT = 2'b01,
    IOC_SW_DONE = 2'b10
  } ioc_sw_state_t;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } ioc_wb_req_t;

  typedef struct packed {
    logic       clk_500k;
    logic       clk_32k;
  } ioc_mf_clk_t;
endpackage

// ==== sim/tb_top.sv ====
/*
  Self-checking testbench for the internal oscillator control block.
  Assumes ioc_top, ioc_pkg and ioc_defines.svh are compiled first; shortened counts via parameters.
*/
`timescale 1ns/1ps
`include "ioc_defines.svh"
module tb_top;
  import ioc_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        clk_i;
  logic        rst_i;
  ioc_wb_req_t wb_req;
  logic [31:0] wb_dat;
  logic        wb_ack;
  logic [2:0]  rst_cfg;
  logic        clk_out_en;
  logic        osc_fail;
  logic        adc_done;
  logic        adc_thr;
  logic        hf_rdy;
  logic        lf_rdy;
  logic        fast_en;
  logic        slow_en;
  logic [2:0]  fast_freq;
  logic [5:0]  trim;
  logic [3:0]  div;
  logic [2:0]  src;
  logic        gpio;
  logic        clk_drv;
  ioc_mf_clk_t mf_tick;
  logic        lf_per_en;
  logic        int_req;
  logic [31:0] rd;
  int          err_total;
  int          n_checks;
  int          cyc_cnt;
  int          k;

  ioc_top #(.TRIM_STEP_CYC(2), .READY_CYC(4), .MF_500K_DIV(4), .MF_32K_DIV(8)) ioc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .reset_clock_source_cfg_i(rst_cfg), .clock_output_pin_enable_i(clk_out_en),
    .osc_fail_i(osc_fail), .adc_done_i(adc_done), .adc_threshold_i(adc_thr),
    .hf_osc_ready_i(hf_rdy), .lf_osc_ready_i(lf_rdy), .fast_osc_en_o(fast_en),
    .slow_osc_en_o(slow_en), .fast_freq_o(fast_freq), .trim_o(trim), .clock_divider_o(div),
    .sys_clk_src_o(src), .ext_clock_input_gpio_o(gpio), .clock_output_drive_o(clk_drv),
    .mf_tick_o(mf_tick), .lf_peripheral_en_o(lf_per_en), .int_req_o(int_req));

  // ------------------------------------------------------------
  // clock, timeout and common tasks
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // whole run needs under a thousand cycles; far above that means a hang
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
    n = 0;
    // no cap here: only the run timeout ends a missing answer
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1);
    rd = wb_dat;
    chk("ack latency", n, 2);
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, 4'hF);
  endtask

  task automatic rc(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, 4'hF);
    chk(name, rd, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(input logic [2:0] v);
    @(posedge clk_i);
    {osc_fail, adc_thr, adc_done} <= v;
    @(posedge clk_i);
    {osc_fail, adc_thr, adc_done} <= 3'h0;
  endtask

  // strap is sampled on the first edge after release
  task automatic do_reset(input logic [2:0] cfg);
    @(posedge clk_i);
    rst_i   <= 1'b1;
    rst_cfg <= cfg;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // moving from the reset source to the strapped one takes four edges
    settle();
    settle();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [2:0] cfgs [3] = '{`IOC_SRC_HF_32M, `IOC_SRC_HF_1M, `IOC_SRC_LF};
    foreach (cfgs[i]) begin
      do_reset(cfgs[i]);
      chk("reset source", src, cfgs[i]);
      rc("current source", `IOC_OFF_CURRENT, cfgs[i]);
      if (cfgs[i] != `IOC_SRC_LF) chk("fast enable", fast_en, 1'b1);
      chk("slow enable", slow_en, 1'b1);
      chk("ext pin free", gpio, 1'b1);
      chk("lf peripheral", lf_per_en, 1'b1);
    end
    do_reset(`IOC_SRC_HF_32M);
    chk("freq out", fast_freq, `IOC_FRQ_32M);
    rc("trim reset", `IOC_OFF_TRIM, 32'h0);
    rc("int enable reset", `IOC_OFF_INT_EN, 32'h0);
    rc("int flag reset", `IOC_OFF_INT_FLAG, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_freq_clock_output_pin();
    for (int f = 0; f < 8; f++) begin
      wr(`IOC_OFF_FRQ_SEL, f);
      settle();
      chk("freq out", fast_freq, f[2:0]);
      rc("freq reg", `IOC_OFF_FRQ_SEL, f);
    end
    for (int b = 1; b >= 0; b--) begin
      @(posedge clk_i);
      clk_out_en <= b[0];
      settle();
      chk("clock out drive", clk_drv, b[0]);
    end
    $display("test freq done");
  endtask

  task automatic t_trim();
    wr(`IOC_OFF_TRIM, 32'h1F);
    #1;
    chk("trim not instant", trim === `IOC_TRIM_MAX_UP, 1'b0);
    rc("trim reg", `IOC_OFF_TRIM, 32'h1F);
    for (k = 0; k < 200 && trim !== `IOC_TRIM_MAX_UP; k++) @(posedge clk_i);
    chk("trim max up", trim, `IOC_TRIM_MAX_UP);
    rc("no trim flag", `IOC_OFF_INT_FLAG, 32'h0);
    chk("slow untouched", slow_en, 1'b1);
    wr(`IOC_OFF_TRIM, 32'h20);
    repeat (20) @(posedge clk_i);
    chk("trim drifting", trim === `IOC_TRIM_MAX_DN, 1'b0);
    for (k = 0; k < 400 && trim !== `IOC_TRIM_MAX_DN; k++) @(posedge clk_i);
    chk("trim max down", trim, `IOC_TRIM_MAX_DN);
    $display("test trim done");
  endtask

  task automatic t_switch();
    wr(`IOC_OFF_INT_FLAG, 32'h0);
    wr(`IOC_OFF_SRC_CTRL, 32'h5F);
    for (k = 0; k < 50 && src !== `IOC_SRC_LF; k++) @(posedge clk_i);
    chk("switch to slow", src, `IOC_SRC_LF);
    chk("divider saturate", div, `IOC_DIV_CODE_MAX);
    rc("current source", `IOC_OFF_CURRENT, `IOC_SRC_LF);
    repeat (10) @(posedge clk_i);
    rc("switch flag", `IOC_OFF_INT_FLAG, 32'h40);
    for (int d = 0; d < 10; d++) begin
      wr(`IOC_OFF_SRC_CTRL, 32'h50 | d);
      settle();
      chk("divider", div, d[3:0]);
    end
    wr(`IOC_OFF_INT_FLAG, 32'h0);
    wr(`IOC_OFF_MAN_EN, 32'h2);
    settle();
    chk("manual fast", fast_en, 1'b1);
    rc("manual reg", `IOC_OFF_MAN_EN, 32'h2);
    hf_rdy <= 1'b0;
    wr(`IOC_OFF_SRC_CTRL, 32'h00);
    repeat (20) @(posedge clk_i);
    chk("waits for ready", src, `IOC_SRC_LF);
    rc("no early flag", `IOC_OFF_INT_FLAG, 32'h0);
    hf_rdy <= 1'b1;
    for (k = 0; k < 50 && src !== `IOC_SRC_HF_32M; k++) @(posedge clk_i);
    chk("switch to fast", src, `IOC_SRC_HF_32M);
    rc("switch flag", `IOC_OFF_INT_FLAG, 32'h40);
    chk("ext pin free", gpio, 1'b1);
    wr(`IOC_OFF_MAN_EN, 32'h0);
    $display("test switch done");
  endtask

  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      {hf_rdy, lf_rdy} <= i[1:0];
      settle();
      rc("ready status", `IOC_OFF_STATUS, i);
    end
    wr(`IOC_OFF_STATUS, 32'h0);
    rc("status read only", `IOC_OFF_STATUS, 32'h3);
    $display("test status done");
  endtask

  task automatic t_int();
    wr(`IOC_OFF_INT_EN, 32'hFF);
    rc("enable bits", `IOC_OFF_INT_EN, 32'hC3);
    wr(`IOC_OFF_INT_EN, 32'h0);
    wr(`IOC_OFF_INT_FLAG, 32'h0);
    pulse(3'b001);
    rc("adc flag", `IOC_OFF_INT_FLAG, 32'h01);
    chk("masked request", int_req, 1'b0);
    repeat (10) @(posedge clk_i);
    rc("adc flag held", `IOC_OFF_INT_FLAG, 32'h01);
    wr(`IOC_OFF_INT_EN, 32'h01);
    settle();
    chk("adc request", int_req, 1'b1);
    wr(`IOC_OFF_INT_EN, 32'h02);
    settle();
    chk("other mask", int_req, 1'b0);
    wr(`IOC_OFF_INT_FLAG, 32'h0);
    pulse(3'b110);
    rc("fail and thr flags", `IOC_OFF_INT_FLAG, 32'h82);
    wr(`IOC_OFF_INT_EN, 32'h80);
    settle();
    chk("fail request", int_req, 1'b1);
    wr(`IOC_OFF_INT_FLAG, 32'h0);
    settle();
    chk("cleared request", int_req, 1'b0);
    wr(`IOC_OFF_INT_FLAG, 32'hFF);
    rc("flag bits", `IOC_OFF_INT_FLAG, 32'hC3);
    wr(`IOC_OFF_INT_FLAG, 32'h0);
    // event lands on the very edge that takes the clearing write
    fork
      wr(`IOC_OFF_INT_FLAG, 32'h0);
      begin
        @(posedge clk_i);
        adc_done <= 1'b1;
        @(posedge clk_i);
        adc_done <= 1'b0;
      end
    join
    rc("set beats clear", `IOC_OFF_INT_FLAG, 32'h01);
    wr(`IOC_OFF_INT_FLAG, 32'h0);
    $display("test int done");
  endtask

  task automatic t_bus_mf();
    int divs [2] = '{8, 4};
    rc("unmapped read", 8'h20, 32'h0);
    wr(8'h24, 32'hAB);
    rc("unmapped write", 8'h24, 32'h0);
    wr(`IOC_OFF_TRIM, 32'h0);
    wb(1'b1, `IOC_OFF_TRIM, 32'h1F, 4'h0);
    rc("lane off write", `IOC_OFF_TRIM, 32'h0);
    // bit 1 of the tick struct is the 500 kHz tick, bit 0 the 32 kHz tick
    for (int i = 0; i < 2; i++) begin
      #1;
      for (k = 0; k < 50 && mf_tick[i] !== 1'b1; k++) begin
        @(posedge clk_i);
        #1;
      end
      k = 0;
      do begin
        @(posedge clk_i);
        #1;
        k++;
      end while (mf_tick[i] !== 1'b1 && k < 50);
      chk("tick period", k, divs[i]);
    end
    $display("test bus and ticks done");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    err_total  = 0;
    n_checks   = 0;
    cyc_cnt    = 0;
    rst_i      = 1'b1;
    wb_req     = '0;
    rst_cfg    = 3'h0;
    clk_out_en = 1'b0;
    osc_fail   = 1'b0;
    adc_done   = 1'b0;
    adc_thr    = 1'b0;
    hf_rdy     = 1'b1;
    lf_rdy     = 1'b1;
    t_reset();
    t_freq_clock_output_pin();
    t_trim();
    t_switch();
    t_status();
    t_int();
    t_bus_mf();
    end_of_test();
  end
endmodule
